// >>> core/burner_pilot_light_off_sequencer.sv
// pilot light-off sequencer: request pilot position, ignition and pilot
// assumes field inputs are asynchronous levels and software uses wishbone
//
// Summary of operation
// - request pilot position: all safety outputs off
// - request pilot position: fan on, channels at pilot
// - prepurge done, ratio control on, clean: position
// - position step exits: lockout, waiting, ignition
// - ignition: pilots and igniters on, mains off
// - ignition: pilot, ion valve, coil, uv closed
// - no fuel state before successful pilot ignition
// - waiting to ignition when ratio control disabled
// - prepurge done, ratio control off: ignition
// - three consecutive ignition failures cause lockout
// - fewer failures: ignition goes to waiting
// - flame present on ignition entry: lockout
// - flame loss: relight limit picks lockout/waiting
// - ignition: alarm or stop lockout, wait waits
// - ignition success with enough pilots: pilot
// - pilot: pilot valves on, igniters, mains off
// - pilot: coil and uv only while relighting
// - low fire or pid above low fire: pilot
// - main permissive in main fuel: pilot
// - high fire above setpoint, low fire off
// - incinerate no assist above waste gas off
// - pid band with standby delay elapsed: pilot
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module burner_pilot_light_off_sequencer
  import pilot_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic        clk_i,                // 20 MHz clock
  input  wire logic        rst_i,                // sync reset, high
  input  wire logic        wb_cyc_i,             // bus cycle
  input  wire logic        wb_stb_i,             // strobe
  input  wire logic        wb_we_i,              // write enable
  input  wire logic [7:0]  wb_adr_i,             // byte address
  input  wire logic [3:0]  wb_sel_i,             // byte lanes
  input  wire logic [31:0] wb_dat_i,             // write data
  output logic      [31:0] wb_dat_o,             // read data
  output logic             wb_ack_o,             // acknowledge
  input  wire logic        alarm_i,              // alarm condition
  input  wire logic        wait_cond_i,          // wait condition
  input  wire logic        prepurge_done_i,      // purge completed ok
  input  wire logic        pilot_pos_proven_i,   // positioners at pilot
  input  wire logic [3:0]  flame_i,              // flame per pilot card
  input  wire logic        main_permissive_i,    // main permissive
  input  wire logic        main_request_i,       // process wants main
  input  wire logic        above_low_fire_i,     // temp > low fire sp
  input  wire logic        above_process_i,      // temp > process sp
  input  wire logic        above_waste_off_i,    // temp > waste gas off
  output logic             pilot_valve_o,        // pilot valve
  output logic             main_shutoff_valve_one_o, // main valve one
  output logic             main_shutoff_valve_two_o, // main valve two
  output logic             ion_valve_o,          // ion card valve
  output logic             ion_coil_o,           // ion card coil
  output logic             uv_ign_enable_o,      // uv contact, 1 closed
  output logic             fan_output_o,         // fan
  output logic             fuel_air_ratio_channels_pilot_o, // to pilot pos
  output logic [2:0]       state_o               // sequencer state
);

  seq_state_e state_q, state_d;
  logic [31:0] ctrl_q, limit_q, times_q, stby_q;
  logic        start_q, clear_q, ack_q;
  logic [1:0]  fail_cnt_q;
  logic [3:0]  relight_cnt_q;
  logic        ign_first_q, flame_seen_q, relight_q, stby_arm_q;
  logic [SYNC_W-1:0] raw, syn;
  logic        alarm, waitc, pp_done, ppos_ok, permissive, main_req;
  logic        hi_lf, hi_proc, hi_wg;
  logic [3:0]  flame;
  logic        flame_any, enough_pilots, ign_fail, ign_loss, run_loss;
  logic        loss_exceeded, stop, fuel_air_ratio_channels_en, pom_ok, pid_band, stby_cond;
  logic        to_pilot, pilot_loss;
  logic [2:0]  pilots_on;
  logic [1:0]  pom;
  main_kind_e  kind;
  logic        bus_req, bus_wr;
  logic [31:0] wmask;

  seq_timer_if tif ();

  // field inputs cross into the clock domain
  assign raw = {alarm_i, wait_cond_i, prepurge_done_i, pilot_pos_proven_i,
                flame_i, main_permissive_i, main_request_i,
                above_low_fire_i, above_process_i, above_waste_off_i};
  sync_two_ff #(.W(SYNC_W)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (raw),
    .q_o   (syn)
  );
  assign {alarm, waitc, pp_done, ppos_ok, flame, permissive, main_req,
          hi_lf, hi_proc, hi_wg} = syn;

  seq_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tmr   (tif.tmr)
  );

  // settings decoded from the control registers
  assign stop     = ctrl_q[CTRL_STOP];
  assign fuel_air_ratio_channels_en  = ctrl_q[CTRL_FUEL_AIR_RATIO_CHANNELS_EN];
  assign pom      = ctrl_q[CTRL_POM_LSB +: 2];
  assign kind     = main_kind_e'(ctrl_q[CTRL_KIND_LSB +: 3]);
  assign pom_ok   = (pom == POM_DISABLED) || (pom == POM_OFF_AT_SP);

  // flame evaluation
  assign flame_any     = |flame;
  assign pilots_on     = 3'({2'b00, flame[0]} + {2'b00, flame[1]}
                         + {2'b00, flame[2]} + {2'b00, flame[3]});
  assign enough_pilots = flame_any && (pilots_on >= limit_q[6:4]);
  assign loss_exceeded = (relight_cnt_q >= limit_q[3:0]);
  assign ign_fail = tif.expired && !ign_first_q && !enough_pilots;
  assign ign_loss = flame_seen_q && !flame_any;
  assign pilot_loss = ctrl_q[CTRL_RELIGHT]
                    ? (relight_q && tif.expired && !flame_any)
                    : !flame_any;
  assign run_loss = !flame_any;

  // return paths from main fuel back to pilot
  assign pid_band  = hi_proc && !hi_lf;
  assign stby_cond = (state_q == ST_MAIN) && (kind == MK_PID) && pid_band
                   && ctrl_q[CTRL_STBY_MP];
  always_comb begin
    to_pilot = permissive && pom_ok;
    unique case (kind)
      MK_LOW_FIRE:  to_pilot = to_pilot || (hi_lf && pom_ok);
      MK_HIGH_FIRE: to_pilot = to_pilot
                    || (hi_proc && ctrl_q[CTRL_LF_DIS] && pom_ok);
      MK_INCIN_NA:  to_pilot = to_pilot || (hi_wg && pom_ok);
      MK_PID:       to_pilot = to_pilot || (hi_lf && pom_ok)
                    || (stby_cond && stby_arm_q && tif.expired);
      default:      to_pilot = to_pilot;
    endcase
  end

  // next state, lockout first, then waiting, then forward
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_q && !alarm && !stop) state_d = ST_PREPURGE;
      end
      ST_PREPURGE: begin
        if (alarm || stop) state_d = ST_LOCKOUT;
        else if (waitc) state_d = ST_WAITING;
        else if (pp_done && fuel_air_ratio_channels_en) state_d = ST_REQ_PPOS;
        else if (pp_done) state_d = ST_IGNITION;
      end
      ST_REQ_PPOS: begin
        if (alarm || stop) state_d = ST_LOCKOUT;
        else if (tif.expired && !ppos_ok) state_d = ST_LOCKOUT;
        else if (waitc) state_d = ST_WAITING;
        else if (ppos_ok) state_d = ST_IGNITION;
      end
      ST_IGNITION: begin
        if (alarm || stop) state_d = ST_LOCKOUT;
        else if (ign_first_q && flame_any) state_d = ST_LOCKOUT;
        else if (ign_loss && loss_exceeded) state_d = ST_LOCKOUT;
        else if (ign_fail && (fail_cnt_q + 2'h1 >= IGN_FAIL_LIMIT))
          state_d = ST_LOCKOUT;
        else if (waitc) state_d = ST_WAITING;
        else if (ign_loss || ign_fail) state_d = ST_WAITING;
        else if (!ign_first_q && enough_pilots)
          state_d = ST_PILOT;
      end
      ST_PILOT: begin
        if (alarm || stop) state_d = ST_LOCKOUT;
        else if (pilot_loss && loss_exceeded) state_d = ST_LOCKOUT;
        else if (waitc || pilot_loss) state_d = ST_WAITING;
        else if (main_req && !permissive) state_d = ST_MAIN;
      end
      ST_MAIN: begin
        if (alarm || stop) state_d = ST_LOCKOUT;
        else if (run_loss && loss_exceeded) state_d = ST_LOCKOUT;
        else if (waitc || run_loss) state_d = ST_WAITING;
        else if (to_pilot) state_d = ST_PILOT;
      end
      ST_WAITING: begin
        if (alarm || stop) state_d = ST_LOCKOUT;
        else if (!waitc && !fuel_air_ratio_channels_en) state_d = ST_IGNITION;
        else if (!waitc) state_d = ST_PREPURGE;
      end
      ST_LOCKOUT: begin
        if (clear_q && !alarm) state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // timer starts: position proof and ignition trial, relight, standby
  always_comb begin
    tif.start = 1'b0;
    tif.load  = times_q[15:0];
    if (state_q != state_d
        && (state_d inside {ST_IGNITION, ST_REQ_PPOS})) begin
      tif.start = 1'b1;
    end else if (state_q == ST_PILOT && state_d == ST_PILOT && !flame_any
                 && !relight_q && ctrl_q[CTRL_RELIGHT]) begin
      tif.start = 1'b1;
      tif.load  = times_q[31:16];
    end else if (stby_cond && !stby_arm_q) begin
      tif.start = 1'b1;
      tif.load  = stby_q[15:0];
    end
  end

  // ignition bookkeeping: entry cycle and flame proven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ign_first_q  <= 1'b0;
      flame_seen_q <= 1'b0;
    end else begin
      ign_first_q  <= (state_d == ST_IGNITION) && (state_q != ST_IGNITION);
      flame_seen_q <= (state_d == ST_IGNITION) && !ign_first_q
                      && (flame_seen_q || flame_any);
    end
  end

  // consecutive failure count, cleared on a lit pilot
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_q == ST_IDLE && start_q)) begin
      fail_cnt_q <= 2'h0;
    end else if (state_q == ST_IGNITION && state_d == ST_PILOT) begin
      fail_cnt_q <= 2'h0;
    end else if (state_q == ST_IGNITION && ign_fail
                 && fail_cnt_q != IGN_FAIL_LIMIT) begin
      fail_cnt_q <= fail_cnt_q + 2'h1;
    end
  end

  // relight attempts, counted on each flame loss, in pilot with relight only once the window runs out
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_q == ST_IDLE && start_q)) begin
      relight_cnt_q <= 4'h0;
    end else if ((state_q == ST_IGNITION && ign_loss && !ign_first_q)
                 || (state_q == ST_PILOT && pilot_loss)
                 || (state_q == ST_MAIN && run_loss)) begin
      if (relight_cnt_q != 4'hF) relight_cnt_q <= relight_cnt_q + 4'h1;
    end
  end

  // relight window and standby arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relight_q  <= 1'b0;
      stby_arm_q <= 1'b0;
    end else begin
      if (state_q != ST_PILOT || flame_any) relight_q <= 1'b0;
      else if (ctrl_q[CTRL_RELIGHT]) relight_q <= 1'b1;
      stby_arm_q <= stby_cond;
    end
  end

  // safety outputs per state, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pilot_valve_o                   <= 1'b0;
      main_shutoff_valve_one_o        <= 1'b0;
      main_shutoff_valve_two_o        <= 1'b0;
      ion_valve_o                     <= 1'b0;
      ion_coil_o                      <= 1'b0;
      uv_ign_enable_o                 <= 1'b0;
      fan_output_o                    <= 1'b0;
      fuel_air_ratio_channels_pilot_o <= 1'b0;
    end else begin
      pilot_valve_o <= state_q inside {ST_IGNITION, ST_PILOT, ST_MAIN};
      ion_valve_o   <= state_q inside {ST_IGNITION, ST_PILOT, ST_MAIN};
      main_shutoff_valve_one_o <= (state_q == ST_MAIN);
      main_shutoff_valve_two_o <= (state_q == ST_MAIN);
      ion_coil_o      <= (state_q == ST_IGNITION)
                         || (state_q == ST_PILOT && relight_q);
      uv_ign_enable_o <= (state_q == ST_IGNITION)
                         || (state_q == ST_PILOT && relight_q);
      fan_output_o    <= state_q inside {ST_PREPURGE, ST_REQ_PPOS,
                                         ST_IGNITION, ST_PILOT, ST_MAIN};
      fuel_air_ratio_channels_pilot_o <= (state_q == ST_REQ_PPOS);
    end
  end
  assign state_o = state_q;

  // wishbone slave: ack one cycle after the strobe, write at ack
  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign bus_wr   = bus_req && wb_we_i && ack_q;
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else ack_q <= bus_req && !ack_q;
  end

  // register writes, pulse bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      limit_q <= LIMIT_RST;
      times_q <= TIMES_RST;
      stby_q  <= STBY_RST;
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        OFS_CTRL:  ctrl_q  <= ((ctrl_q & ~wmask) | (wb_dat_i & wmask))
                              & CTRL_MASK;
        OFS_LIMIT: limit_q <= ((limit_q & ~wmask) | (wb_dat_i & wmask))
                              & LIMIT_MASK;
        OFS_TIMES: times_q <= (times_q & ~wmask) | (wb_dat_i & wmask);
        OFS_STBY:  stby_q  <= ((stby_q & ~wmask) | (wb_dat_i & wmask))
                              & STBY_MASK;
        default:   ;
      endcase
    end
  end

  // start and clear command pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
      clear_q <= 1'b0;
    end else begin
      start_q <= bus_wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]
                 && wb_dat_i[CTRL_START];
      clear_q <= bus_wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]
                 && wb_dat_i[CTRL_CLEAR];
    end
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !ack_q) begin
      unique case (wb_adr_i)
        OFS_CTRL:   wb_dat_o <= ctrl_q;
        OFS_LIMIT:  wb_dat_o <= limit_q;
        OFS_TIMES:  wb_dat_o <= times_q;
        OFS_STBY:   wb_dat_o <= stby_q;
        OFS_STATUS: wb_dat_o <= {8'h00, fuel_air_ratio_channels_pilot_o,
                                 fan_output_o, uv_ign_enable_o, ion_coil_o,
                                 ion_valve_o, main_shutoff_valve_two_o,
                                 main_shutoff_valve_one_o, pilot_valve_o,
                                 flame, relight_cnt_q, 2'b00, fail_cnt_q,
                                 1'b0, state_q};
        default:    wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : burner_pilot_light_off_sequencer
`default_nettype wire

// >>> core/pilot_seq_pkg.sv
// constants, register map and state codes of the pilot light-off sequencer
// assumes a 20 MHz system clock and a 32-bit classic wishbone register bus
package pilot_seq_pkg;

  // time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TIME_TICK_NS  = 1_000_000; // one millisecond
  localparam int unsigned TICK_CYCLES_DEF = TIME_TICK_NS / CLK_PERIOD_NS;

  // sequencer figures
  localparam logic [1:0] IGN_FAIL_LIMIT = 2'h3;
  localparam int unsigned SYNC_W = 13;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_TIMES  = 8'h08;
  localparam logic [7:0] OFS_STBY   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control register fields
  localparam int unsigned CTRL_START    = 0; // write-one pulse
  localparam int unsigned CTRL_STOP     = 1;
  localparam int unsigned CTRL_CLEAR    = 2; // write-one pulse
  localparam int unsigned CTRL_FUEL_AIR_RATIO_CHANNELS_EN  = 3;
  localparam int unsigned CTRL_LF_DIS   = 4;
  localparam int unsigned CTRL_STBY_MP  = 5;
  localparam int unsigned CTRL_RELIGHT  = 6;
  localparam int unsigned CTRL_POM_LSB  = 8;  // two bits
  localparam int unsigned CTRL_KIND_LSB = 12; // three bits
  localparam logic [31:0] CTRL_MASK  = 32'h0000_737A;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] LIMIT_MASK = 32'h0000_007F;
  localparam logic [31:0] LIMIT_RST  = 32'h0000_0013; // 1 pilot, 3 relights
  localparam logic [31:0] TIMES_RST  = 32'h2710_2710; // 10 s and 10 s
  localparam logic [31:0] STBY_MASK  = 32'h0000_FFFF;
  localparam logic [31:0] STBY_RST   = 32'h0000_EA60; // 60 s

  // pilot-off modes
  localparam logic [1:0] POM_DISABLED = 2'h0;
  localparam logic [1:0] POM_OFF_AT_SP = 2'h1;

  // main fuel state kinds
  typedef enum logic [2:0] {
    MK_LOW_FIRE  = 3'h0,
    MK_HIGH_FIRE = 3'h1,
    MK_INCIN     = 3'h2,
    MK_INCIN_NA  = 3'h3,
    MK_PID       = 3'h4
  } main_kind_e;

  // sequencer states, gray along the light-off path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_PREPURGE = 3'h1,
    ST_REQ_PPOS = 3'h3,
    ST_IGNITION = 3'h2,
    ST_PILOT    = 3'h6,
    ST_MAIN     = 3'h7,
    ST_WAITING  = 3'h5,
    ST_LOCKOUT  = 3'h4
  } seq_state_e;

endpackage : pilot_seq_pkg

// >>> core/seq_timer_if.sv
// handshake between the sequencer and its millisecond delay timer
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface seq_timer_if;
  logic        start;   // reload and run
  logic [15:0] load;    // delay in ms
  logic        expired; // level until next start
  modport ctl (output start, output load, input expired);
  modport tmr (input start, input load, output expired);
endinterface : seq_timer_if
`default_nettype wire

// >>> core/sync_two_ff.sv
// two-flop synchroniser for a group of field inputs
// assumes the inputs are static levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i, // system clock
  input  wire logic         rst_i, // synchronous reset
  input  wire logic [W-1:0] d_i,   // asynchronous levels
  output logic      [W-1:0] q_o    // synchronised levels
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : sync_two_ff
`default_nettype wire

// >>> core/seq_timer.sv
// millisecond delay timer with its own tick divider
// assumes one clock; start restarts the divider and the count
`timescale 1ns/100ps
`default_nettype none
module seq_timer #(
  parameter int unsigned TICK_CYCLES = 20000
) (
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // synchronous reset
  seq_timer_if.tmr  tmr     // control from the sequencer
);
  logic [15:0] div_q;
  logic [15:0] count_q;
  logic        active_q;
  logic        expired_q;
  logic        tick;

  assign tick        = (div_q == 16'(TICK_CYCLES - 1));
  assign tmr.expired = expired_q;

  // tick divider, one enable pulse per ms
  always_ff @(posedge clk_i) begin
    if (rst_i || tmr.start || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // delay count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q   <= 16'h0000;
      active_q  <= 1'b0;
      expired_q <= 1'b0;
    end else if (tmr.start) begin
      count_q   <= tmr.load;
      active_q  <= 1'b1;
      expired_q <= 1'b0;
    end else if (active_q && tick) begin
      if (count_q <= 16'h0001) begin
        count_q   <= 16'h0000;
        active_q  <= 1'b0;
        expired_q <= 1'b1;
      end else begin
        count_q <= count_q - 16'h0001;
      end
    end
  end
endmodule : seq_timer
`default_nettype wire

// >>> sim/field_io_model.sv
// field side model: pilot positioner and flame scanners
// assumes it is driven straight from the sequencer outputs
`timescale 1ns/100ps
`default_nettype none
module field_io_model (
  input  wire logic       clk_i,   // clock
  input  wire logic       fuel_air_ratio_channels_i,  // channels sent to pilot
  input  wire logic       pilot_i, // pilot valve open
  input  wire logic       lit_i,   // pilots light when fuelled
  input  wire logic       stuck_i, // faulty scanner sees flame
  input  wire logic [4:0] pdly_i,  // positioner travel cycles
  output logic            ppos_o,  // position proven
  output logic      [3:0] flame_o  // flame per card
);
  logic [4:0] pcnt_q = 5'h0;
  logic [2:0] fcnt_q = 3'h0;
  // travel and light-off delays, prompt or slow
  always @(posedge clk_i) begin
    pcnt_q <= !fuel_air_ratio_channels_i ? 5'h0 : (pcnt_q == pdly_i) ? pcnt_q : pcnt_q + 5'h1;
    fcnt_q <= !pilot_i ? 3'h0 : (fcnt_q == 3'h3) ? fcnt_q : fcnt_q + 3'h1;
  end
  // proof and flame levels
  assign ppos_o  = fuel_air_ratio_channels_i && (pcnt_q == pdly_i);
  assign flame_o = (stuck_i || (lit_i && fcnt_q == 3'h3)) ? 4'hF : 4'h0;
endmodule : field_io_model
`default_nettype wire

// >>> sim/pilot_seq_chk.sv
// port assertions for the pilot light-off sequencer
// assumes outputs trail the state by one clock
`timescale 1ns/100ps
`default_nettype none
module pilot_seq_chk
  import pilot_seq_pkg::*;
(
  input wire logic       clk_i,                           // clock
  input wire logic       rst_i,                           // sync reset
  input wire logic       alarm_i,                         // alarm pin
  input wire logic [2:0] state_o,                         // state
  input wire logic       pilot_valve_o,                   // pilot
  input wire logic       main_shutoff_valve_one_o,        // main one
  input wire logic       main_shutoff_valve_two_o,        // main two
  input wire logic       ion_valve_o,                     // ion valve
  input wire logic       ion_coil_o,                      // ion coil
  input wire logic       uv_ign_enable_o,                 // uv contact
  input wire logic       fan_output_o,                    // fan
  input wire logic       fuel_air_ratio_channels_pilot_o  // to pilot
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ppos_safe_off: assert property (
    state_o == ST_REQ_PPOS |=> !(pilot_valve_o | main_shutoff_valve_one_o |
    main_shutoff_valve_two_o | ion_valve_o | ion_coil_o | uv_ign_enable_o))
    else $error("safety output on in position step");
  a_ppos_fan_on: assert property (
    state_o == ST_REQ_PPOS |=> fan_output_o && fuel_air_ratio_channels_pilot_o)
    else $error("fan or channels wrong in position step");
  a_ign_outputs: assert property (
    state_o == ST_IGNITION |=> pilot_valve_o && ion_valve_o && ion_coil_o &&
    uv_ign_enable_o && !main_shutoff_valve_one_o && !main_shutoff_valve_two_o)
    else $error("ignition outputs wrong");
  a_pilot_outputs: assert property (
    state_o == ST_PILOT |=> pilot_valve_o && ion_valve_o &&
    !main_shutoff_valve_one_o && !main_shutoff_valve_two_o)
    else $error("pilot outputs wrong");
  a_fuel_after_ign: assert property (
    state_o == ST_PILOT && $past(state_o) != ST_PILOT &&
    $past(state_o) != ST_MAIN |-> $past(state_o) == ST_IGNITION)
    else $error("pilot reached without ignition");
  a_ppos_entry: assert property (
    state_o == ST_REQ_PPOS && $past(state_o) != ST_REQ_PPOS
    |-> $past(state_o) == ST_PREPURGE) else $error("bad entry to position");
  a_ppos_exit: assert property (
    !$past(rst_i) && $past(state_o) == ST_REQ_PPOS |-> state_o inside
    {ST_REQ_PPOS, ST_IGNITION, ST_WAITING, ST_LOCKOUT})
    else $error("bad exit from position");
  a_alarm_lock: assert property (
    alarm_i [*5] |-> state_o inside {ST_IDLE, ST_LOCKOUT})
    else $error("alarm did not lock out");
endmodule : pilot_seq_chk
bind burner_pilot_light_off_sequencer pilot_seq_chk chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .alarm_i(alarm_i), .state_o(state_o),
  .pilot_valve_o(pilot_valve_o), .ion_valve_o(ion_valve_o),
  .main_shutoff_valve_one_o(main_shutoff_valve_one_o),
  .main_shutoff_valve_two_o(main_shutoff_valve_two_o),
  .ion_coil_o(ion_coil_o), .uv_ign_enable_o(uv_ign_enable_o),
  .fan_output_o(fan_output_o),
  .fuel_air_ratio_channels_pilot_o(fuel_air_ratio_channels_pilot_o));
`default_nettype wire

// >>> sim/burner_pilot_light_off_sequencer_tb.sv
// testbench for the pilot light-off sequencer
// assumes the field model closes the loop on valves and positioners
`timescale 1ns/100ps
`default_nettype none
module burner_pilot_light_off_sequencer_tb;
  import pilot_seq_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic        alarm = 0, wt = 0, ppd = 0, perm = 0, mreq = 0, alf = 0;
  logic        lit = 1, stuck = 0, ppos, pv, s1, s2, iv, ic, uv, fan, fuel_air_ratio_channels;
  logic        apr = 0;
  logic [4:0]  pdly = 5'h02;
  logic [3:0]  flame;
  logic [2:0]  st, mp;
  int          failures = 0, samples_checked = 0, seed = 4225;
  // clock
  always #25 clk_i = ~clk_i;
  burner_pilot_light_off_sequencer #(.TICK_CYCLES(4)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .alarm_i(alarm), .wait_cond_i(wt),
    .prepurge_done_i(ppd), .pilot_pos_proven_i(ppos), .flame_i(flame),
    .main_permissive_i(perm), .main_request_i(mreq), .above_low_fire_i(alf),
    .above_process_i(apr), .above_waste_off_i(1'b0), .pilot_valve_o(pv),
    .main_shutoff_valve_one_o(s1), .main_shutoff_valve_two_o(s2),
    .ion_valve_o(iv), .ion_coil_o(ic), .uv_ign_enable_o(uv),
    .fan_output_o(fan), .fuel_air_ratio_channels_pilot_o(fuel_air_ratio_channels), .state_o(st));
  field_io_model field_u (
    .clk_i(clk_i), .fuel_air_ratio_channels_i(fuel_air_ratio_channels), .pilot_i(pv), .lit_i(lit),
    .stuck_i(stuck), .pdly_i(pdly), .ppos_o(ppos), .flame_o(flame));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task go(input logic [2:0] s);
    int n;
    n = 0;
    while (st !== s && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk({29'h0, st}, {29'h0, s});
  endtask : go
  task conclude;
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // watchdog
  initial begin
    #(50 * 20000);
    failures++;
    conclude;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_LIMIT, 32'h0);
    chk(rdat, LIMIT_RST);
    bus(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, OFS_TIMES, 32'h0005_0005);
    mp = 3'h1 + 3'({$random(seed)} % 4);
    bus(1'b1, OFS_LIMIT, {25'h0, mp, 4'h3});
    // positioned light-off, then main and back
    bus(1'b1, OFS_CTRL, 32'h0000_0009);
    go(ST_PREPURGE);
    repeat ({$random(seed)} % 8) @(posedge clk_i);
    ppd <= 1'b1;
    go(ST_REQ_PPOS);
    go(ST_IGNITION);
    go(ST_PILOT);
    mreq <= 1'b1;
    go(ST_MAIN);
    perm <= 1'b1;
    go(ST_PILOT);
    perm <= 1'b0;
    go(ST_MAIN);
    alf <= 1'b1;
    go(ST_PILOT);
    alf  <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_1018);
    go(ST_MAIN);
    apr  <= 1'b1;
    go(ST_PILOT);
    mreq <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0002);
    go(ST_LOCKOUT);
    bus(1'b1, OFS_CTRL, 32'h0000_0004);
    go(ST_IDLE);
    // slow positioner, wait then alarm in ignition
    pdly <= 5'h0C;
    lit  <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0009);
    go(ST_REQ_PPOS);
    wt <= 1'b1;
    go(ST_WAITING);
    wt <= 1'b0;
    go(ST_IGNITION);
    alarm <= 1'b1;
    go(ST_LOCKOUT);
    repeat (2) @(posedge clk_i);
    alarm <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0004);
    go(ST_IDLE);
    // positioner never proves: lockout
    pdly <= 5'h1F;
    bus(1'b1, OFS_CTRL, 32'h0000_0009);
    go(ST_REQ_PPOS);
    go(ST_LOCKOUT);
    bus(1'b1, OFS_CTRL, 32'h0000_0004);
    go(ST_IDLE);
    // three failed trials without ratio control
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    go(ST_IGNITION);
    for (int i = 0; i < 2; i++) begin
      go(ST_WAITING);
      go(ST_IGNITION);
    end
    go(ST_LOCKOUT);
    bus(1'b1, OFS_CTRL, 32'h0000_0004);
    go(ST_IDLE);
    // flame already present at ignition entry
    ppd <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    go(ST_PREPURGE);
    stuck <= 1'b1;
    repeat (4) @(posedge clk_i);
    ppd <= 1'b1;
    go(ST_IGNITION);
    go(ST_LOCKOUT);
    conclude;
  end
endmodule : burner_pilot_light_off_sequencer_tb
`default_nettype wire
